// ### lsh_pkg.sv
package lsh_pkg;
  // Register offsets of the bank
  localparam logic [7:0] LSH_OFS_HIST_A = 8'h09;
  localparam logic [7:0] LSH_OFS_HIST_B = 8'h0a;
  localparam logic [7:0] LSH_OFS_MASK_A = 8'h0b;
  localparam logic [7:0] LSH_OFS_MASK_B = 8'h0c;
  // Reset values; both counters start at zero so both limit flags start set
  localparam logic [7:0] LSH_RST_HIST_A = 8'h20;
  localparam logic [7:0] LSH_RST_HIST_B = 8'h02;
  localparam logic [7:0] LSH_RST_MASK = 8'h00;
  // Group A field positions
  localparam int LSH_A_LOST = 0;
  localparam int LSH_A_QUIET = 1;
  localparam int LSH_A_HALT = 2;
  localparam int LSH_A_MASTER = 3;
  localparam int LSH_A_NOISE = 4;
  localparam int LSH_A_NLIM = 5;
  localparam int LSH_A_CHANGE = 6;
  localparam int LSH_A_UNK_INV = 7;
  // Group B field positions
  localparam int LSH_B_IDLE = 0;
  localparam int LSH_B_EXPIRY = 1;
  localparam int LSH_B_ACTIVE = 2;
  localparam int LSH_B_UNK_VAL = 3;
  localparam int LSH_B_CASC = 4;
  localparam int LSH_B_EBUF = 5;
  localparam int LSH_B_SUPER = 6;
  localparam int LSH_B_SPARE = 7;
  // Symbol pair codes, first symbol in the upper five bits
  localparam logic [9:0] LSH_PAIR_QUIET = 10'h000;
  localparam logic [9:0] LSH_PAIR_HALT = 10'h084;
  localparam logic [9:0] LSH_PAIR_MASTER = 10'h080;
  localparam logic [9:0] LSH_PAIR_IDLE = 10'h3ff;
  localparam logic [9:0] LSH_PAIR_JK = 10'h311;
  // Consecutive pair and event counts
  localparam logic [3:0] LSH_RUN_LONG = 4'h8;
  localparam logic [3:0] LSH_RUN_IDLE = 4'h2;
  localparam logic [4:0] LSH_NOISE_MIN = 5'h10;
  // Cascade start window
  localparam int LSH_CLK_NS = 25;
  localparam int LSH_CASC_NS = 80;
  localparam logic [2:0] LSH_CASC_CYC = 3'(LSH_CASC_NS / LSH_CLK_NS);

  // Recognised line states
  typedef enum logic [3:0] {
    LS_NONE = 4'b0000,
    LS_LOST = 4'b0001,
    LS_QUIET = 4'b0010,
    LS_HALT = 4'b0011,
    LS_MASTER = 4'b0100,
    LS_NOISE = 4'b0101,
    LS_IDLE = 4'b0110,
    LS_ACTIVE = 4'b0111,
    LS_UNKNOWN = 4'b1000
  } lsh_state_type;

  // One register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lsh_req_type;
endpackage

// ### lsh_history.sv
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module lsh_history
  import lsh_pkg::*;
(
  input wire logic i_clk_sys, // 40 MHz clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic [7:0] i_addr, // Register address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [7:0] o_rdata, // Read data, cycle after strobe
  input wire logic i_signal_detect_in, // Signal detect pin
  input wire logic i_cascade_armed, // Cascade armed pin
  input wire logic i_cascade_go, // Cascade go pin
  input wire logic i_pair_valid, // New symbol pair this cycle
  input wire logic [9:0] i_pair_code, // Received symbol pair
  input wire logic i_noise_event, // Noise event pulse
  input wire logic i_noise_cnt_zero, // Noise counter at zero
  input wire logic i_noise_reload, // Nonzero noise start written
  input wire logic i_state_cnt_zero, // State counter at zero
  input wire logic i_state_reload, // Nonzero state start written
  input wire logic i_eb_error, // Elastic buffer over/underflow
  output logic o_history_a_pending, // Group A summary bit
  output logic o_history_b_pending, // Group B summary bit
  output lsh_state_type o_line_state // Current line state
);

  // Pair code that keeps a state alive
  function automatic logic [9:0] hold_code(input lsh_state_type s);
    case (s)
      LS_HALT: hold_code = LSH_PAIR_HALT;
      LS_MASTER: hold_code = LSH_PAIR_MASTER;
      LS_IDLE: hold_code = LSH_PAIR_IDLE;
      default: hold_code = LSH_PAIR_QUIET;
    endcase
  endfunction

  lsh_req_type req; // Bundled bus request
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // Pin synchronisers, first stage read only by the second
  logic [2:0] sync1_reg; // First stage
  logic [2:0] sync2_reg; // Second stage
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 3'h1;
      sync2_reg <= 3'h1;
    end else begin
      sync1_reg <= {i_cascade_go, i_cascade_armed, i_signal_detect_in};
      sync2_reg <= sync1_reg;
    end
  end

  logic sd_low; // Receiver lost its signal
  logic armed_s; // Synchronised armed level
  logic go_s; // Synchronised go level
  assign sd_low = !sync2_reg[0];
  assign armed_s = sync2_reg[1];
  assign go_s = sync2_reg[2];

  // State of the bank
  logic [7:0] hist_a_reg, hist_a_next; // History A
  logic [7:0] hist_b_reg, hist_b_next; // History B
  logic [7:0] mask_a_reg, mask_a_next; // Mask A
  logic [7:0] mask_b_reg, mask_b_next; // Mask B
  logic [7:0] rdata_reg, rdata_next; // Read data
  lsh_state_type state_reg, state_next; // Line state
  lsh_state_type known_reg, known_next; // Last known state
  logic [9:0] prev_reg, prev_next; // Previous pair
  logic [3:0] run_reg, run_next; // Consecutive equal pairs
  logic [4:0] noise_reg, noise_next; // Noise events seen
  logic st_armed_reg, st_armed_next; // Expiry may be cleared
  logic armed_d_reg, armed_d_next; // Armed level last cycle
  logic [2:0] cas_reg, cas_next; // Cascade window count
  logic [7:0] set_a, set_b; // Hardware set terms

  // Next-state logic of the whole bank
  always_comb begin
    state_next = state_reg;
    known_next = known_reg;
    prev_next = prev_reg;
    run_next = run_reg;
    noise_next = noise_reg;
    st_armed_next = st_armed_reg;
    armed_d_next = armed_s;
    cas_next = cas_reg;
    mask_a_next = mask_a_reg;
    mask_b_next = mask_b_reg;
    rdata_next = 8'h00;
    set_a = 8'h00;
    set_b = 8'h00;

    // Noise events saturate at the threshold
    if (i_noise_event && noise_reg < LSH_NOISE_MIN) begin
      noise_next = noise_reg + 5'h01;
    end

    // Line state recognition
    if (sd_low) begin
      state_next = LS_LOST;
    end else if (i_pair_valid) begin
      prev_next = i_pair_code;
      if (i_pair_code != prev_reg) begin
        run_next = 4'h1;
      end else if (run_reg != 4'hf) begin
        run_next = run_reg + 4'h1;
      end
      if (i_pair_code == LSH_PAIR_QUIET && run_next >= LSH_RUN_LONG) begin
        state_next = LS_QUIET;
      end else if (i_pair_code == LSH_PAIR_HALT &&
                   run_next >= LSH_RUN_LONG) begin
        state_next = LS_HALT;
      end else if (i_pair_code == LSH_PAIR_MASTER &&
                   run_next >= LSH_RUN_LONG) begin
        state_next = LS_MASTER;
      end else if (i_pair_code == LSH_PAIR_IDLE &&
                   run_next >= LSH_RUN_IDLE) begin
        state_next = LS_IDLE;
      end else if (i_pair_code == LSH_PAIR_JK) begin
        state_next = LS_ACTIVE;
        set_b[LSH_B_ACTIVE] = 1'b1;
      end else if (noise_next >= LSH_NOISE_MIN) begin
        state_next = LS_NOISE;
      end else if (state_reg == LS_ACTIVE || state_reg == LS_NOISE) begin
        state_next = state_reg; // Data follows start; noise persists
      end else if (state_reg == LS_UNKNOWN ||
                   i_pair_code != hold_code(state_reg)) begin
        state_next = LS_UNKNOWN;
      end
      // Super idle is counted on the idle run itself
      if (i_pair_code == LSH_PAIR_IDLE && run_next == LSH_RUN_LONG) begin
        set_b[LSH_B_SUPER] = 1'b1;
      end
    end else if (noise_next >= LSH_NOISE_MIN) begin
      // Noise alone is enough; no pair has to arrive
      state_next = LS_NOISE;
    end

    // Entry into a new state marks it; old marks stay
    if (state_next != state_reg) begin
      set_a[LSH_A_CHANGE] = 1'b1;
      case (state_next)
        LS_LOST: set_a[LSH_A_LOST] = 1'b1;
        LS_QUIET: set_a[LSH_A_QUIET] = 1'b1;
        LS_HALT: set_a[LSH_A_HALT] = 1'b1;
        LS_MASTER: set_a[LSH_A_MASTER] = 1'b1;
        LS_NOISE: set_a[LSH_A_NOISE] = 1'b1;
        LS_IDLE: set_b[LSH_B_IDLE] = 1'b1;
        LS_ACTIVE: set_b[LSH_B_ACTIVE] = 1'b1;
        LS_UNKNOWN: begin
          if (known_reg == LS_IDLE || known_reg == LS_ACTIVE) begin
            set_b[LSH_B_UNK_VAL] = 1'b1;
          end else begin
            set_a[LSH_A_UNK_INV] = 1'b1;
          end
        end
        default: begin
        end
      endcase
      if (state_next != LS_UNKNOWN) begin
        known_next = state_next;
      end
      // Fresh noise count for each known state other than noise and active
      if (state_next != LS_UNKNOWN && state_next != LS_NOISE &&
          state_next != LS_ACTIVE) begin
        noise_next = 5'h00;
      end
    end

    // Counter limits, held while the counters sit at zero
    set_a[LSH_A_NLIM] = i_noise_cnt_zero;
    set_b[LSH_B_EXPIRY] = i_state_cnt_zero;
    if (i_state_cnt_zero) begin
      st_armed_next = 1'b0;
    end else if (i_state_reload) begin
      st_armed_next = 1'b1;
    end

    // Cascade window opens when armed is released
    if (armed_d_reg && !armed_s) begin
      cas_next = LSH_CASC_CYC;
    end else if (go_s) begin
      cas_next = 3'h0;
    end else if (cas_reg != 3'h0) begin
      cas_next = cas_reg - 3'h1;
      if (cas_reg == 3'h1) begin
        set_b[LSH_B_CASC] = 1'b1;
      end
    end
    set_b[LSH_B_EBUF] = i_eb_error;

    // Sticky update; a set in the same cycle beats a clear
    hist_a_next = hist_a_reg | set_a;
    hist_b_next = hist_b_reg | set_b;
    if (req.wr) begin
      if (req.addr == LSH_OFS_HIST_A) begin
        hist_a_next = (hist_a_reg & req.wdata) | set_a;
        // Noise limit leaves only through a reload
        hist_a_next[LSH_A_NLIM] = hist_a_reg[LSH_A_NLIM] |
                                  set_a[LSH_A_NLIM];
      end else if (req.addr == LSH_OFS_HIST_B) begin
        hist_b_next = (hist_b_reg & req.wdata) | set_b;
        // Expiry clears only once a reload has been seen
        if (!st_armed_reg) begin
          hist_b_next[LSH_B_EXPIRY] = hist_b_reg[LSH_B_EXPIRY] |
                                      set_b[LSH_B_EXPIRY];
        end
      end else if (req.addr == LSH_OFS_MASK_A) begin
        mask_a_next = req.wdata;
      end else if (req.addr == LSH_OFS_MASK_B) begin
        mask_b_next = req.wdata;
      end
    end
    if (i_noise_reload && !i_noise_cnt_zero) begin
      hist_a_next[LSH_A_NLIM] = 1'b0;
    end

    // Read decode; unmapped addresses read zero
    if (req.rd) begin
      if (req.addr == LSH_OFS_HIST_A) begin
        rdata_next = hist_a_reg;
      end else if (req.addr == LSH_OFS_HIST_B) begin
        rdata_next = hist_b_reg;
      end else if (req.addr == LSH_OFS_MASK_A) begin
        rdata_next = mask_a_reg;
      end else if (req.addr == LSH_OFS_MASK_B) begin
        rdata_next = mask_b_reg;
      end
    end
  end

  // Registers only
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_a_reg <= LSH_RST_HIST_A;
      hist_b_reg <= LSH_RST_HIST_B;
      mask_a_reg <= LSH_RST_MASK;
      mask_b_reg <= LSH_RST_MASK;
      rdata_reg <= 8'h00;
      state_reg <= LS_NONE;
      known_reg <= LS_NONE;
      prev_reg <= 10'h000;
      run_reg <= 4'h0;
      noise_reg <= 5'h00;
      st_armed_reg <= 1'b0;
      armed_d_reg <= 1'b1;
      cas_reg <= 3'h0;
    end else begin
      hist_a_reg <= hist_a_next;
      hist_b_reg <= hist_b_next;
      mask_a_reg <= mask_a_next;
      mask_b_reg <= mask_b_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      known_reg <= known_next;
      prev_reg <= prev_next;
      run_reg <= run_next;
      noise_reg <= noise_next;
      st_armed_reg <= st_armed_next;
      armed_d_reg <= armed_d_next;
      cas_reg <= cas_next;
    end
  end

  // Summary bits follow masks without delay
  assign o_history_a_pending = |(hist_a_reg & mask_a_reg);
  assign o_history_b_pending = |(hist_b_reg & mask_b_reg);
  assign o_rdata = rdata_reg;
  assign o_line_state = state_reg;

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_sticky_a_bits: assert property (
    !(i_wr && i_addr == LSH_OFS_HIST_A) && !i_noise_reload
    |=> (hist_a_reg & $past(hist_a_reg)) == $past(hist_a_reg))
    else $error("history A bit fell without a write");
  a_pend_a_sum: assert property (
    o_history_a_pending == |(hist_a_reg & mask_a_reg))
    else $error("group A pending wrong");
  a_pend_b_sum: assert property (
    (|(hist_b_reg & mask_b_reg)) |-> o_history_b_pending)
    else $error("group B pending missing");
  a_lost_sets: assert property (
    sd_low && state_reg != LS_LOST |=> hist_a_reg[LSH_A_LOST])
    else $error("signal lost bit not set");
  a_quiet_entry: assert property (
    state_reg != LS_QUIET ##1 state_reg == LS_QUIET
    |-> $past(run_next) >= LSH_RUN_LONG && hist_a_reg[LSH_A_QUIET])
    else $error("quiet entered too early or unmarked");
  a_change_mark: assert property (
    state_next != state_reg |=> hist_a_reg[LSH_A_CHANGE])
    else $error("line change bit not set");
  a_active_mark: assert property (
    i_pair_valid && i_pair_code == LSH_PAIR_JK && !sd_low
    |=> hist_b_reg[LSH_B_ACTIVE] && state_reg == LS_ACTIVE)
    else $error("active bit not set on JK");
  a_casc_late: assert property (
    armed_d_reg && !armed_s ##1 !go_s [*3]
    |=> hist_b_reg[LSH_B_CASC])
    else $error("cascade error not flagged");
  a_ebuf_mark: assert property (
    i_eb_error |=> hist_b_reg[LSH_B_EBUF])
    else $error("elastic buffer bit not set");
  a_spare_quiet: assert property (
    !i_wr |=> !$rose(hist_b_reg[LSH_B_SPARE]))
    else $error("spare bit rose by itself");
  a_read_data: assert property (
    i_rd && i_addr == LSH_OFS_HIST_B |=> o_rdata == $past(hist_b_reg))
    else $error("history B read wrong");
  a_noise_entry: assert property (
    !sd_low && !i_pair_valid && i_noise_event &&
    noise_reg == LSH_NOISE_MIN - 5'h01 && state_reg != LS_NOISE
    |=> state_reg == LS_NOISE && hist_a_reg[LSH_A_NOISE])
    else $error("noise state not entered");
  a_idle_entry: assert property (
    i_pair_valid && !sd_low && i_pair_code == LSH_PAIR_IDLE &&
    prev_reg == LSH_PAIR_IDLE |=> state_reg == LS_IDLE)
    else $error("idle state not entered");
  a_nlim_hold: assert property (
    hist_a_reg[LSH_A_NLIM] && !i_noise_reload |=> hist_a_reg[LSH_A_NLIM])
    else $error("noise limit bit fell without reload");
  a_expiry_hold: assert property (
    hist_b_reg[LSH_B_EXPIRY] && !st_armed_reg |=> hist_b_reg[LSH_B_EXPIRY])
    else $error("expiry bit fell without reload");
  a_unk_inv_mark: assert property (
    state_next == LS_UNKNOWN &&
    state_reg inside {LS_LOST, LS_QUIET, LS_HALT, LS_MASTER, LS_NOISE}
    |=> hist_a_reg[LSH_A_UNK_INV])
    else $error("unknown after invalid not set");
  a_unk_val_mark: assert property (
    state_next == LS_UNKNOWN && (state_reg == LS_IDLE ||
    state_reg == LS_ACTIVE) |=> hist_b_reg[LSH_B_UNK_VAL])
    else $error("unknown after valid not set");
  a_super_mark: assert property (
    i_pair_valid && !sd_low && i_pair_code == LSH_PAIR_IDLE &&
    run_next == LSH_RUN_LONG |=> hist_b_reg[LSH_B_SUPER])
    else $error("super idle bit not set");

  c_quiet: cover property (state_reg == LS_QUIET);
  c_unk_valid: cover property ($rose(hist_b_reg[LSH_B_UNK_VAL]));
  c_casc_err: cover property ($rose(hist_b_reg[LSH_B_CASC]));
  c_super_idle: cover property ($rose(hist_b_reg[LSH_B_SUPER]));
  c_noise_state: cover property ($rose(hist_a_reg[LSH_A_NOISE]));

endmodule // lsh_history

// ### lsh_cpu_model.sv
`timescale 1ns/100ps
// Management processor on the register port
module lsh_cpu_model
  import lsh_pkg::*;
(
  input wire logic i_clk_sys, // Device clock
  input wire logic [7:0] i_rdata, // Read data from the bank
  output lsh_req_type o_req // Bus request to the bank
);
  // Idle bus at time zero
  initial begin
    o_req = '0;
  end

  // One-cycle write strobe
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    // Released lines flip so stale values are never trusted
    o_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    o_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    #1 d = i_rdata;
  endtask
endmodule // lsh_cpu_model

// ### line_state_condition_history_test.sv
`timescale 1ns/100ps
module line_state_condition_history_test;
  import lsh_pkg::*;
  localparam logic [7:0] RA = LSH_OFS_HIST_A; // Short address names
  localparam logic [7:0] RB = LSH_OFS_HIST_B;
  logic clk_sys = 1'b0; // Bench clock
  logic rst_n = 1'b0; // Reset, active low
  lsh_req_type req; // Request from processor model
  logic [7:0] rdata; // Read data
  logic sd = 1'b1; // Signal detect pin
  logic armed = 1'b1; // Cascade armed pin
  logic go = 1'b1; // Cascade go pin
  logic pv = 1'b0; // Pair valid
  logic [9:0] pc = 10'h000; // Pair code
  logic nev = 1'b0; // Noise event
  logic ncz = 1'b0; // Noise counter zero
  logic nrl = 1'b0; // Noise reload
  logic szr = 1'b0; // State counter zero
  logic srl = 1'b0; // State reload
  logic ebe = 1'b0; // Elastic buffer fault
  logic pa; // Group A summary
  logic pb; // Group B summary
  lsh_state_type ls; // Line state seen
  int fail_count = 0; // Mismatches
  int total_checks = 0; // Comparisons
  logic [7:0] e; // Expected value
  logic [7:0] w; // Random write data

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  lsh_cpu_model lsh_cpu_model_inst (.i_clk_sys(clk_sys), .i_rdata(rdata),
    .o_req(req));
  lsh_history lsh_history_inst (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_addr(req.addr), .i_wdata(req.wdata), .i_wr(req.wr), .i_rd(req.rd),
    .o_rdata(rdata), .i_signal_detect_in(sd), .i_cascade_armed(armed),
    .i_cascade_go(go), .i_pair_valid(pv), .i_pair_code(pc),
    .i_noise_event(nev), .i_noise_cnt_zero(ncz), .i_noise_reload(nrl),
    .i_state_cnt_zero(szr), .i_state_reload(srl), .i_eb_error(ebe),
    .o_history_a_pending(pa), .o_history_b_pending(pb), .o_line_state(ls));

  function automatic logic [7:0] bit_of(input int i);
    return 8'h01 << i;
  endfunction

  // Random pair that is never a line state code
  function automatic logic [9:0] rnd_pair();
    logic [9:0] p;
    p = 10'($urandom);
    if (p inside {LSH_PAIR_QUIET, LSH_PAIR_HALT, LSH_PAIR_MASTER,
        LSH_PAIR_IDLE, LSH_PAIR_JK}) begin
      p = p ^ 10'h001; // Flipped codes are all unused
    end
    return p;
  endfunction

  // Masked byte compare
  task automatic chk_val(input string n, input logic [7:0] m,
      input logic [7:0] x, input logic [7:0] g);
    total_checks++;
    if ((g & m) !== (x & m)) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, x & m, g & m);
    end
  endtask

  // Single flag compare
  task automatic chk_bit(input string n, input logic x, input logic g);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value %s exp %b got %b", n, x, g);
    end
  endtask

  // Read a register and compare the masked bits
  task automatic chk_reg(input string n, input logic [7:0] a,
      input logic [7:0] m, input logic [7:0] x);
    logic [7:0] d;
    lsh_cpu_model_inst.reg_read(a, d);
    chk_val(n, m, x, d);
  endtask

  // Burst of back-to-back pairs, then a settling gap
  task automatic run(input logic [9:0] c, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pv <= 1'b1;
      pc <= c;
    end
    @(posedge clk_sys);
    pv <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // Burst of noise events
  task automatic noise(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      nev <= 1'b1;
    end
    @(posedge clk_sys);
    nev <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // Write zero to both history registers
  task automatic clr();
    lsh_cpu_model_inst.reg_write(RA, 8'h00);
    lsh_cpu_model_inst.reg_write(RB, 8'h00);
  endtask

  // Nonzero reload of both counters, then clear
  task automatic reload();
    @(posedge clk_sys);
    nrl <= 1'b1;
    srl <= 1'b1;
    @(posedge clk_sys);
    nrl <= 1'b0;
    srl <= 1'b0;
    clr();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h5037ecc0));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk_reg("hist_a", RA, 8'hff, bit_of(LSH_A_NLIM));
    chk_reg("hist_b", RB, 8'hff, bit_of(LSH_B_EXPIRY));
    chk_reg("mask_a", LSH_OFS_MASK_A, 8'hff, 8'h00);
    chk_reg("mask_b", LSH_OFS_MASK_B, 8'hff, 8'h00);
    chk_reg("unmapped", 8'h0d, 8'hff, 8'h00);
    $display("test reset done");
    // Limit flags ignore clears until a reload
    clr();
    chk_reg("nlim_hold", RA, 8'hff, bit_of(LSH_A_NLIM));
    chk_reg("exp_hold", RB, 8'hff, bit_of(LSH_B_EXPIRY));
    reload();
    chk_reg("nlim_clr", RA, 8'hff, 8'h00);
    chk_reg("exp_clr", RB, 8'hff, 8'h00);
    @(posedge clk_sys);
    ncz <= 1'b1;
    szr <= 1'b1;
    @(posedge clk_sys);
    ncz <= 1'b0;
    szr <= 1'b0;
    chk_reg("nlim_set", RA, 8'hff, bit_of(LSH_A_NLIM));
    chk_reg("exp_set", RB, 8'hff, bit_of(LSH_B_EXPIRY));
    reload();
    $display("test limits done");
    // Group A line states accumulate
    run(LSH_PAIR_QUIET, 8);
    e = bit_of(LSH_A_QUIET) | bit_of(LSH_A_CHANGE);
    chk_reg("quiet", RA, e, e);
    chk_val("state", 8'h0f, 8'(LS_QUIET), 8'(ls));
    run(rnd_pair(), 1);
    run(LSH_PAIR_HALT, 7);
    run(rnd_pair(), 1);
    e = bit_of(LSH_A_UNK_INV) | bit_of(LSH_A_QUIET);
    chk_reg("halt7", RA, e | bit_of(LSH_A_HALT), e);
    run(LSH_PAIR_HALT, 8);
    e = e | bit_of(LSH_A_HALT);
    chk_reg("halt", RA, e, e);
    run(rnd_pair(), 1);
    run(LSH_PAIR_MASTER, 8);
    chk_reg("master", RA, e | 8'h08, e | 8'h08);
    chk_val("state", 8'h0f, 8'(LS_MASTER), 8'(ls));
    $display("test group_a done");
    // Sixteen noise events, one short first
    clr();
    run(rnd_pair(), 1);
    noise(15);
    chk_reg("noise15", RA, bit_of(LSH_A_NOISE), 8'h00);
    noise(1);
    e = bit_of(LSH_A_NOISE);
    chk_reg("noise16", RA, e, e);
    $display("test noise done");
    // Group B line states
    clr();
    run(LSH_PAIR_IDLE, 2);
    e = bit_of(LSH_B_IDLE) | bit_of(LSH_B_SUPER);
    chk_reg("idle", RB, e, bit_of(LSH_B_IDLE));
    run(rnd_pair(), 1);
    e = bit_of(LSH_B_UNK_VAL);
    chk_reg("unk_val", RB, e, e);
    run(LSH_PAIR_IDLE, 8);
    e = bit_of(LSH_B_SUPER);
    chk_reg("super", RB, e, e);
    run(LSH_PAIR_JK, 1);
    e = bit_of(LSH_B_ACTIVE);
    chk_reg("active", RB, e, e);
    chk_val("state", 8'h0f, 8'(LS_ACTIVE), 8'(ls));
    $display("test group_b done");
    // Signal loss goes through the pin synchroniser
    @(posedge clk_sys);
    sd <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk_reg("lost", RA, 8'h01, 8'h01);
    @(posedge clk_sys);
    sd <= 1'b1;
    repeat (4) @(posedge clk_sys);
    $display("test signal done");
    // Cascade go already high, then go never comes, then buffer fault
    clr();
    @(posedge clk_sys);
    armed <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk_reg("casc_ok", RB, bit_of(LSH_B_CASC), 8'h00);
    @(posedge clk_sys);
    armed <= 1'b1;
    go <= 1'b0;
    repeat (4) @(posedge clk_sys);
    armed <= 1'b0;
    repeat (8) @(posedge clk_sys);
    ebe <= 1'b1;
    @(posedge clk_sys);
    ebe <= 1'b0;
    e = bit_of(LSH_B_CASC) | bit_of(LSH_B_EBUF);
    chk_reg("b_events", RB, 8'hff, e);
    w = 8'($urandom) | 8'h10;
    lsh_cpu_model_inst.reg_write(RB, w);
    e = e & w;
    chk_reg("b_write", RB, 8'hff, e);
    $display("test events done");
    // Summary bits follow history and mask
    for (int i = 0; i < 8; i++) begin
      lsh_cpu_model_inst.reg_write(LSH_OFS_MASK_B, bit_of(i));
      @(negedge clk_sys);
      chk_bit("pend_b", e[i], pb);
    end
    reload();
    lsh_cpu_model_inst.reg_write(LSH_OFS_MASK_A, 8'($urandom) | 8'h21);
    @(negedge clk_sys);
    chk_bit("pend_a_zero", 1'b0, pa);
    @(posedge clk_sys);
    ncz <= 1'b1;
    @(posedge clk_sys);
    ncz <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bit("pend_a_set", 1'b1, pa);
    lsh_cpu_model_inst.reg_write(LSH_OFS_MASK_A, 8'hdf);
    @(negedge clk_sys);
    chk_bit("pend_a_mask", 1'b0, pa);
    $display("test summary done");
    tally_and_finish();
  end
endmodule // line_state_condition_history_test
